// file: edge_div.sv
// Programmable counter that divides a stream of input events by a ratio.
`timescale 1ns/1ps
module edge_div
	import synth_pkg::*;
#(
	parameter int W = RATIO_W
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic in_evt,
	input wire logic [W-1:0] ratio,
	output logic pulse
);
	logic [W-1:0] cnt_reg;

	// The ratio is compared live on every input event, not sampled, so a new ratio takes effect at the next input event.
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			cnt_reg <= '0;
			pulse <= 1'b0;
		end else if (ce) begin
			pulse <= 1'b0;
			if (in_evt) begin
				if (cnt_reg >= ratio - W'(1)) begin
					cnt_reg <= '0;
					pulse <= 1'b1;
				end else begin
					cnt_reg <= cnt_reg + W'(1);
				end
			end
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	// A frozen clock enable holds the pulse, so only running cycles are checked.
	a_div_one_pulse: assert property (pulse && ce |=> !pulse) else $error("divider pulse longer than one cycle");
	a_div_pulse_cause: assert property ($rose(pulse) |-> $past(in_evt) && $past(ce)) else $error("divider pulse without input");
endmodule

// file: pfd_backlash.sv
// Phase and frequency detector with backlash hold for dead-zone removal.
`timescale 1ns/1ps
module pfd_backlash
	import synth_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic ref_evt,
	input wire logic div_evt,
	pump_if.src pump
);
	pfd_state_t state_reg;
	pfd_state_t state_next;
	logic [HOLD_W-1:0] hold_reg;

	// Next state; edges that arrive during the hold are dropped, a known limit of short backlash.
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			PFD_IDLE: begin
				if (ref_evt && div_evt) state_next = PFD_HOLD;
				else if (ref_evt) state_next = PFD_UP;
				else if (div_evt) state_next = PFD_DN;
			end
			PFD_UP: begin
				if (div_evt) state_next = PFD_HOLD;
			end
			PFD_DN: begin
				if (ref_evt) state_next = PFD_HOLD;
			end
			PFD_HOLD: begin
				if (hold_reg == HOLD_W'(BACKLASH_CYC - 1)) state_next = PFD_IDLE;
			end
		endcase
	end

	// State and backlash counter.
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			state_reg <= PFD_IDLE;
			hold_reg <= '0;
		end else if (ce) begin
			state_reg <= state_next;
			hold_reg <= (state_reg == PFD_HOLD) ? hold_reg + HOLD_W'(1) : '0;
		end
	end

	assign pump.up = (state_reg == PFD_UP) || (state_reg == PFD_HOLD);
	assign pump.dn = (state_reg == PFD_DN) || (state_reg == PFD_HOLD);

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	a_backlash_hold: assert property ($rose(pump.up && pump.dn) && ce |-> (pump.up && pump.dn)[*2])
		else $error("backlash shorter than two cycles");
	a_source_lead: assert property (state_reg == PFD_IDLE && ce && ref_evt && !div_evt |=> pump.up && !pump.dn)
		else $error("source not raised on leading reference");
	c_both_hold: cover property (state_reg == PFD_UP ##1 state_reg == PFD_HOLD);
endmodule

// file: pump_if.sv
// Up and down pump drive carried from a phase detector to the core.
`timescale 1ns/1ps
interface pump_if;
	logic up;
	logic dn;
	modport src (output up, output dn);
	modport snk (input up, input dn);
endinterface

// file: synth_core.sv
// Digital core of the dual synthesizer: dividers, modulator, detectors and pump gains.
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module synth_core
	import synth_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic rf_vco_input,
	input wire logic if_vco_input,
	input wire logic ref_in,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rdata,
	output logic rf_main_pump_out_up,
	output logic rf_main_pump_out_dn,
	output logic rf_integral_pump_out_up,
	output logic rf_integral_pump_out_dn,
	output logic if_pump_out_up,
	output logic if_pump_out_dn,
	output logic [GAIN_W-1:0] if_pump_gain,
	output logic [GAIN_W-1:0] rf_main_pump_gain,
	output logic [GAIN_W-1:0] rf_main_pump_boosted,
	output logic [GAIN_W-1:0] rf_integral_pump_gain
);
	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [PIN_COUNT-1:0] pin_in;
	logic [SYNC_STAGES-1:0] sync_reg [PIN_COUNT];
	logic [PIN_COUNT-1:0] level_reg;
	logic [PIN_COUNT-1:0] pin_rise;
	logic wr_frac;
	logic wr_ref;
	logic wr_if;
	logic [FRAC_W-2:0] frac_hi_reg;
	logic [N_W-1:0] n_pending_reg;
	logic [N_W-1:0] n_active_reg;
	logic [REF_W-1:0] ref_ratio_reg;
	logic [IF_W-1:0] if_ratio_reg;
	logic [TAP_W-1:0] tap_sel_reg;
	logic pump_gain_low_bit;
	logic pump_gain_high_bit;
	logic [FRAC_W-1:0] frac_eff;
	logic [FRAC_W-1:0] acc1_reg;
	logic [FRAC_W-1:0] acc2_reg;
	logic [FRAC_W:0] acc1_next;
	logic [FRAC_W:0] acc2_next;
	logic carry2_prev_reg;
	logic [CORR_W:0] corr_sum;
	logic [CORR_W-1:0] corr_reg;
	logic [RATIO_W-1:0] rf_ratio;
	logic rf_div_pulse;
	logic rf_pulse_prev_reg;
	logic rf_div_rise;
	logic mod_step;
	logic if_div_pulse;
	logic ref_div_pulse;
	logic [TAP_CNT_W-1:0] tap_cnt_reg;
	logic [TAP_COUNT-1:0] tap_evt;
	logic [TAP_W-1:0] tap_idx;
	logic if_ref_evt;
	logic [DATA_W-1:0] rd_mux;
	pump_if rf_pump ();
	pump_if if_pump ();

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	assign pin_in = {ref_in, if_vco_input, rf_vco_input};

	// Three stages per pin; the filtered level only moves once stages two and three agree.
	for (genvar p = 0; p < PIN_COUNT; p++) begin : g_sync
		always_ff @(posedge clk_sys) begin
			if (!rst_b) begin
				sync_reg[p] <= '0;
				level_reg[p] <= 1'b0;
			end else if (ce) begin
				sync_reg[p] <= {sync_reg[p][SYNC_STAGES-2:0], pin_in[p]};
				if (sync_reg[p][1] == sync_reg[p][2]) begin
					level_reg[p] <= sync_reg[p][2];
				end
			end
		end
		assign pin_rise[p] = sync_reg[p][1] && sync_reg[p][2] && !level_reg[p];
	end

	// ----------------------------------------------------------------
	// Programming words
	// ----------------------------------------------------------------
	assign wr_frac = reg_wr && (reg_addr == ADDR_WORD_FRAC);
	assign wr_ref = reg_wr && (reg_addr == ADDR_WORD_REF);
	assign wr_if = reg_wr && (reg_addr == ADDR_WORD_IF);

	// Fractional word; only the upper bits exist as storage.
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			frac_hi_reg <= '0;
		end else if (ce && wr_frac) begin
			frac_hi_reg <= reg_wdata[FRAC_HI_MSB:FRAC_HI_LSB];
		end
	end

	// Integer ratio is staged and only goes live with the fractional word, so no false ratio is seen.
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			n_pending_reg <= N_RST;
			n_active_reg <= N_RST;
		end else if (ce) begin
			if (wr_ref) begin
				n_pending_reg <= reg_wdata[N_MSB:N_LSB];
			end
			if (wr_frac) begin
				n_active_reg <= n_pending_reg;
			end
		end
	end

	// Reference ratio.
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			ref_ratio_reg <= REF_RST;
		end else if (ce && wr_ref) begin
			ref_ratio_reg <= reg_wdata[REF_MSB:REF_LSB];
		end
	end

	// IF ratio, tap selector and pump gain bits.
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			if_ratio_reg <= IF_RST;
			tap_sel_reg <= '0;
			pump_gain_low_bit <= 1'b0;
			pump_gain_high_bit <= 1'b0;
		end else if (ce && wr_if) begin
			if_ratio_reg <= reg_wdata[IF_MSB:IF_LSB];
			tap_sel_reg <= reg_wdata[TAP_MSB:TAP_LSB];
			pump_gain_low_bit <= reg_wdata[GAIN_LO_POS];
			pump_gain_high_bit <= reg_wdata[GAIN_HI_POS];
		end
	end

	// ----------------------------------------------------------------
	// RF fractional divider and modulator
	// ----------------------------------------------------------------
	edge_div #(.W(RATIO_W)) u_rf_div (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.ce(ce),
		.in_evt(pin_rise[PIN_RF]),
		.ratio(rf_ratio),
		.pulse(rf_div_pulse)
	);

	// Edges of the divider pulse: rising feeds the detector, falling steps the modulator.
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			rf_pulse_prev_reg <= 1'b0;
		end else if (ce) begin
			rf_pulse_prev_reg <= rf_div_pulse;
		end
	end
	assign rf_div_rise = rf_div_pulse && !rf_pulse_prev_reg;
	assign mod_step = !rf_div_pulse && rf_pulse_prev_reg;

	// Two cascaded first-order stages; the forced low bit makes every sequence full length.
	assign frac_eff = {frac_hi_reg, 1'b1};
	assign acc1_next = {1'b0, acc1_reg} + {1'b0, frac_eff};
	assign acc2_next = {1'b0, acc2_reg} + {1'b0, acc1_next[FRAC_W-1:0]};
	assign corr_sum = {2'h0, acc1_next[FRAC_W]} + {2'h0, acc2_next[FRAC_W]} + 3'h1 - {2'h0, carry2_prev_reg};

	// Accumulators are never cleared by a load; only reset clears them.
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			acc1_reg <= '0;
			acc2_reg <= '0;
			carry2_prev_reg <= 1'b0;
			corr_reg <= CORR_ZERO;
		end else if (ce && mod_step) begin
			acc1_reg <= acc1_next[FRAC_W-1:0];
			acc2_reg <= acc2_next[FRAC_W-1:0];
			carry2_prev_reg <= acc2_next[FRAC_W];
			corr_reg <= corr_sum[CORR_W-1:0];
		end
	end

	// Correction code 0..3 stands for -1..+2 around the integer ratio.
	assign rf_ratio = RATIO_W'(n_active_reg) + RATIO_W'(corr_reg) - RATIO_W'(CORR_ZERO);

	// ----------------------------------------------------------------
	// IF and reference dividers
	// ----------------------------------------------------------------
	edge_div #(.W(IF_W)) u_if_div (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.ce(ce),
		.in_evt(pin_rise[PIN_IF]),
		.ratio(if_ratio_reg),
		.pulse(if_div_pulse)
	);

	edge_div #(.W(REF_W)) u_ref_div (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.ce(ce),
		.in_evt(pin_rise[PIN_REF]),
		.ratio(ref_ratio_reg),
		.pulse(ref_div_pulse)
	);

	// Binary chain after the reference divider.
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			tap_cnt_reg <= '0;
		end else if (ce && ref_div_pulse) begin
			tap_cnt_reg <= tap_cnt_reg + TAP_CNT_W'(1);
		end
	end

	// Tap k fires on every 2^k-th reference pulse.
	for (genvar k = 0; k < TAP_COUNT; k++) begin : g_tap
		localparam logic [TAP_CNT_W-1:0] MASK = TAP_CNT_W'((1 << k) - 1);
		assign tap_evt[k] = ref_div_pulse && ((tap_cnt_reg & MASK) == MASK);
	end
	assign tap_idx = (tap_sel_reg > TAP_MAX) ? TAP_MAX : tap_sel_reg;
	assign if_ref_evt = tap_evt[tap_idx];

	// ----------------------------------------------------------------
	// Phase detectors
	// ----------------------------------------------------------------
	pfd_backlash u_rf_pfd (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.ce(ce),
		.ref_evt(pin_rise[PIN_REF]),
		.div_evt(rf_div_rise),
		.pump(rf_pump.src)
	);

	pfd_backlash u_if_pfd (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.ce(ce),
		.ref_evt(if_ref_evt),
		.div_evt(if_div_pulse),
		.pump(if_pump.src)
	);

	// Pump drive outputs; the RF detector feeds both RF pumps.
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			rf_main_pump_out_up <= 1'b0;
			rf_main_pump_out_dn <= 1'b0;
			rf_integral_pump_out_up <= 1'b0;
			rf_integral_pump_out_dn <= 1'b0;
			if_pump_out_up <= 1'b0;
			if_pump_out_dn <= 1'b0;
		end else if (ce) begin
			rf_main_pump_out_up <= rf_pump.up;
			rf_main_pump_out_dn <= rf_pump.dn;
			rf_integral_pump_out_up <= rf_pump.up && !pump_gain_high_bit;
			rf_integral_pump_out_dn <= rf_pump.dn && !pump_gain_high_bit;
			if_pump_out_up <= if_pump.up;
			if_pump_out_dn <= if_pump.dn;
		end
	end

	// Pump gain codes.
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			if_pump_gain <= IF_GAIN_HI;
			rf_main_pump_gain <= MAIN_GAIN_HI;
			rf_main_pump_boosted <= BOOST_GAIN_HI;
			rf_integral_pump_gain <= INTEG_GAIN_HI;
		end else if (ce) begin
			if_pump_gain <= pump_gain_low_bit ? IF_GAIN_LO : IF_GAIN_HI;
			rf_main_pump_gain <= pump_gain_low_bit ? MAIN_GAIN_LO : MAIN_GAIN_HI;
			rf_main_pump_boosted <= pump_gain_low_bit ? BOOST_GAIN_LO : BOOST_GAIN_HI;
			if (pump_gain_high_bit) begin
				rf_integral_pump_gain <= GAIN_OFF;
			end else begin
				rf_integral_pump_gain <= pump_gain_low_bit ? INTEG_GAIN_LO : INTEG_GAIN_HI;
			end
		end
	end

	// ----------------------------------------------------------------
	// Register read port
	// ----------------------------------------------------------------
	always_comb begin
		rd_mux = '0;
		unique case (reg_addr)
			ADDR_WORD_FRAC: rd_mux[FRAC_HI_MSB:FRAC_HI_LSB] = frac_hi_reg;
			ADDR_WORD_REF: begin
				rd_mux[N_MSB:N_LSB] = n_pending_reg;
				rd_mux[REF_MSB:REF_LSB] = ref_ratio_reg;
			end
			ADDR_WORD_IF: begin
				rd_mux[IF_MSB:IF_LSB] = if_ratio_reg;
				rd_mux[TAP_MSB:TAP_LSB] = tap_sel_reg;
				rd_mux[GAIN_LO_POS] = pump_gain_low_bit;
				rd_mux[GAIN_HI_POS] = pump_gain_high_bit;
			end
			ADDR_STATUS: begin
				rd_mux[RATIO_W-1:0] = rf_ratio;
				rd_mux[STAT_CORR_LSB+CORR_W-1:STAT_CORR_LSB] = corr_reg;
			end
			default: rd_mux = '0;
		endcase
	end

	// Read data stands only in the cycle after the strobe; unmapped addresses read zero.
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			reg_rdata <= '0;
		end else if (ce) begin
			reg_rdata <= reg_rd ? rd_mux : '0;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	a_step_after_pulse: assert property ($changed(acc1_reg) |-> $past(mod_step) && $past(ce))
		else $error("modulator moved without a divider falling edge");
	a_acc_adds_frac: assert property (ce && mod_step |=> acc1_reg == FRAC_W'($past(acc1_reg) + $past(frac_eff)))
		else $error("first accumulator did not add the forced-odd fraction");
	a_frac_load_mask: assert property (ce && wr_frac |=> frac_hi_reg == $past(reg_wdata[FRAC_HI_MSB:FRAC_HI_LSB]))
		else $error("fraction load wrong");
	a_ratio_range: assert property (rf_ratio + RATIO_W'(1) >= RATIO_W'(n_active_reg)
		&& rf_ratio <= RATIO_W'(n_active_reg) + RATIO_W'(2))
		else $error("momentary ratio out of range");
	a_n_held_back: assert property (ce && wr_ref |=> n_active_reg == $past(n_active_reg))
		else $error("integer ratio applied before fraction word");
	a_n_applied: assert property (ce && wr_frac |=> n_active_reg == $past(n_pending_reg))
		else $error("integer ratio not applied with fraction word");
	a_acc_kept: assert property (ce && wr_frac && !mod_step |=> acc1_reg == $past(acc1_reg)
		&& acc2_reg == $past(acc2_reg))
		else $error("fraction load disturbed modulator state");
	a_if_ratio_load: assert property (ce && wr_if |=> if_ratio_reg == $past(reg_wdata[IF_MSB:IF_LSB]))
		else $error("IF ratio load wrong");
	a_integral_off: assert property (pump_gain_high_bit && ce |=> rf_integral_pump_gain == GAIN_OFF
		&& !rf_integral_pump_out_up && !rf_integral_pump_out_dn)
		else $error("integral pump active with upper gain bit set");
	a_tap_zero: assert property (tap_sel_reg == '0 |-> if_ref_evt == ref_div_pulse)
		else $error("tap zero does not pass the reference divider");
	a_rf_pump_follow: assert property (ce |=> rf_main_pump_out_up == $past(rf_pump.up))
		else $error("RF main pump does not follow RF detector");

	c_frac_step: cover property (ce && mod_step && corr_sum[CORR_W-1:0] == 2'h3);
	c_n_update: cover property (wr_ref ##[1:20] wr_frac);
	c_if_hold: cover property (if_pump_out_up && if_pump_out_dn);
endmodule

// file: synth_core_tb.sv
// Self-checking testbench of the synthesizer core: registers, gains, ratios and pumps.
`timescale 1ns/1ps
module synth_core_tb;
	import synth_pkg::*;
	// ----------------------------------------------------------------
	// Signals and instances
	// ----------------------------------------------------------------
	logic clk_sys = 1'b0, rst_b = 1'b0, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [DATA_W-1:0] reg_wdata = '0, reg_rdata, d;
	logic rf_vco_input, if_vco_input, ref_in, mu, md, iu, idn, fu, fd;
	logic [GAIN_W-1:0] g_if, g_main, g_boost, g_int;
	int rf_half = 0, if_half = 0, ref_half = 0, fails = 0, cmp_count = 0, n;
	synth_partner pm (.clk_sys(clk_sys), .rf_half(rf_half), .if_half(if_half), .ref_half(ref_half),
		.rf_vco_input(rf_vco_input), .if_vco_input(if_vco_input), .ref_in(ref_in));
	synth_core uut (.clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .rf_vco_input(rf_vco_input),
		.if_vco_input(if_vco_input), .ref_in(ref_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rf_main_pump_out_up(mu),
		.rf_main_pump_out_dn(md), .rf_integral_pump_out_up(iu), .rf_integral_pump_out_dn(idn),
		.if_pump_out_up(fu), .if_pump_out_dn(fd), .if_pump_gain(g_if), .rf_main_pump_gain(g_main),
		.rf_main_pump_boosted(g_boost), .rf_integral_pump_gain(g_int));
	// Free-running 100 MHz clock.
	initial begin
		forever #5 clk_sys = ~clk_sys;
	end
	// ----------------------------------------------------------------
	// Bus and check tasks
	// ----------------------------------------------------------------
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe, so they are sampled just past that edge.
	task rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task tick(input int c);
		repeat (c) @(posedge clk_sys);
		#1;
	endtask
	task results;
		$display("checks %0d fails %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Watchdog well beyond the few thousand cycles the sequence needs.
	initial begin
		repeat (10_000) @(posedge clk_sys);
		fails++;
		results();
	end
	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (16) @(posedge clk_sys);
		rst_b <= 1'b1;
		tick(1);
		chk({g_if, g_main, g_boost, g_int}, {IF_GAIN_HI, MAIN_GAIN_HI, BOOST_GAIN_HI, INTEG_GAIN_HI});
		chk({mu, md, iu, idn, fu, fd}, 0);
		// All four gain codes and tap codes 0 to 3, with the widest IF ratio read back each time.
		for (int g = 0; g < 4; g++) begin
			wr(ADDR_WORD_IF, (32'h0000_3fff << IF_LSB) | (32'(g) << GAIN_LO_POS) | 32'(g));
			tick(3);
			chk({g_if, g_main, g_boost}, g[0] ? {IF_GAIN_LO, MAIN_GAIN_LO, BOOST_GAIN_LO} :
				{IF_GAIN_HI, MAIN_GAIN_HI, BOOST_GAIN_HI});
			chk(g_int, g[1] ? GAIN_OFF : (g[0] ? INTEG_GAIN_LO : INTEG_GAIN_HI));
			rd(ADDR_WORD_IF, d);
			chk(d & 32'h003f_ff1f, (32'h0000_3fff << IF_LSB) | (32'(g) << GAIN_LO_POS) | 32'(g));
		end
		// A write while the clock enable is low must leave the word untouched.
		@(posedge clk_sys) ce <= 1'b0;
		wr(ADDR_WORD_IF, 32'h0000_0000);
		ce <= 1'b1;
		rd(ADDR_WORD_IF, d);
		chk(d & 32'h003f_ff1f, (32'h0000_3fff << IF_LSB) | 32'h0000_001b);
		wr(ADDR_WORD_FRAC, 32'hffff_ffff);
		rd(ADDR_WORD_FRAC, d);
		chk(d & 32'h003f_ffff, 32'h003f_ffff);
		rd(4'h9, d);
		chk(d, 0);
		// New integer ratio waits for the fraction word, then the modulator dithers around it.
		wr(ADDR_WORD_REF, (32'h0000_0004 << REF_LSB) | 32'h0000_0028);
		rd(ADDR_STATUS, d);
		chk(32'(d[9:0] >= 10'h020 && d[9:0] <= 10'h023), 1);
		wr(ADDR_WORD_FRAC, 32'h0020_0000);
		@(posedge clk_sys) rf_half <= 4;
		tick(1500);
		@(posedge clk_sys) rf_half <= 0;
		tick(10);
		rd(ADDR_STATUS, d);
		chk(32'(d[9:0]), 32'(d[13:12]) + 32'd39);
		// Reference alone: the detector left in sink first passes a hold, then settles on source.
		@(posedge clk_sys) ref_half <= 5;
		n = 0;
		while ({mu, md} !== 2'b10 && n < 100) begin
			tick(1);
			n++;
		end
		chk({mu, md, iu, idn}, 4'b1000);
		// Tap 3 passes only every eighth reference divider pulse, so the IF source starts late.
		tick(80);
		chk({fu, fd}, 2'b00);
		tick(300);
		chk({fu, fd}, 2'b10);
		// Divider edges now arrive late: both pumps stand high for the backlash time, then clear.
		@(posedge clk_sys) rf_half <= 4;
		if_half <= 4;
		n = 0;
		while ((mu & md) !== 1'b1 && n < 1000) begin
			tick(1);
			n++;
		end
		chk({mu, md}, 2'b11);
		repeat (BACKLASH_CYC - 1) begin
			tick(1);
			chk({mu, md}, 2'b11);
		end
		tick(1);
		chk(32'(mu & md), 0);
		results();
	end
endmodule

// file: synth_partner.sv
// Behavioural model of the reference oscillator and the two VCOs driving the core pins.
`timescale 1ns/1ps
module synth_partner
	import synth_pkg::*;
(
	input wire logic clk_sys,
	input wire logic [31:0] rf_half,
	input wire logic [31:0] if_half,
	input wire logic [31:0] ref_half,
	output logic rf_vco_input,
	output logic if_vco_input,
	output logic ref_in
);
	// ----------------------------------------------------------------
	// Pin toggling
	// ----------------------------------------------------------------
	logic [PIN_COUNT-1:0] pin = '0;
	int cnt [PIN_COUNT] = '{0, 0, 0};
	int half [PIN_COUNT];
	// A half period of zero parks the pin low, so no stray edge reaches the dividers.
	always_comb begin
		half[PIN_RF] = rf_half;
		half[PIN_IF] = if_half;
		half[PIN_REF] = ref_half;
	end
	// Each pin flips after its half period; callers keep it at 4 or more for the synchronisers.
	always_ff @(posedge clk_sys) begin
		for (int i = 0; i < PIN_COUNT; i++) begin
			if (half[i] == 0) begin
				pin[i] <= 1'b0;
				cnt[i] <= 0;
			end else if (cnt[i] >= half[i] - 1) begin
				pin[i] <= ~pin[i];
				cnt[i] <= 0;
			end else begin
				cnt[i] <= cnt[i] + 1;
			end
		end
	end
	assign rf_vco_input = pin[PIN_RF];
	assign if_vco_input = pin[PIN_IF];
	assign ref_in = pin[PIN_REF];
endmodule

// file: synth_pkg.sv
// Shared constants, field layout and types of the fractional-N synthesizer core.
package synth_pkg;
	// ----------------------------------------------------------------
	// Register port and map
	// ----------------------------------------------------------------
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] ADDR_WORD_FRAC = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_WORD_REF = 4'h1;
	localparam logic [ADDR_W-1:0] ADDR_WORD_IF = 4'h2;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h3;
	localparam int FRAC_HI_MSB = 21;
	localparam int FRAC_HI_LSB = 0;
	localparam int N_MSB = 8;
	localparam int N_LSB = 0;
	localparam int REF_MSB = 21;
	localparam int REF_LSB = 12;
	localparam int IF_MSB = 21;
	localparam int IF_LSB = 8;
	localparam int TAP_MSB = 2;
	localparam int TAP_LSB = 0;
	localparam int GAIN_LO_POS = 3;
	localparam int GAIN_HI_POS = 4;
	localparam int STAT_CORR_LSB = 12;
	// ----------------------------------------------------------------
	// Widths and reset values
	// ----------------------------------------------------------------
	localparam int FRAC_W = 23;
	localparam int N_W = 9;
	localparam int RATIO_W = 10;
	localparam int IF_W = 14;
	localparam int REF_W = 10;
	localparam int TAP_W = 3;
	localparam int TAP_COUNT = 5;
	localparam int TAP_CNT_W = 4;
	localparam int CORR_W = 2;
	localparam int GAIN_W = 6;
	localparam int SYNC_STAGES = 3;
	localparam int PIN_COUNT = 3;
	localparam int PIN_RF = 0;
	localparam int PIN_IF = 1;
	localparam int PIN_REF = 2;
	localparam logic [N_W-1:0] N_RST = 9'h021;
	localparam logic [IF_W-1:0] IF_RST = 14'h0080;
	localparam logic [REF_W-1:0] REF_RST = 10'h004;
	localparam logic [TAP_W-1:0] TAP_MAX = 3'h4;
	localparam logic [CORR_W-1:0] CORR_ZERO = 2'h1;
	// ----------------------------------------------------------------
	// Pump gains; IF gain in half bias units, others in whole units
	// ----------------------------------------------------------------
	localparam logic [GAIN_W-1:0] IF_GAIN_HI = 6'h03;
	localparam logic [GAIN_W-1:0] IF_GAIN_LO = 6'h01;
	localparam logic [GAIN_W-1:0] MAIN_GAIN_HI = 6'h03;
	localparam logic [GAIN_W-1:0] MAIN_GAIN_LO = 6'h01;
	localparam logic [GAIN_W-1:0] BOOST_GAIN_HI = 6'h0f;
	localparam logic [GAIN_W-1:0] BOOST_GAIN_LO = 6'h05;
	localparam logic [GAIN_W-1:0] INTEG_GAIN_HI = 6'h24;
	localparam logic [GAIN_W-1:0] INTEG_GAIN_LO = 6'h0c;
	localparam logic [GAIN_W-1:0] GAIN_OFF = 6'h00;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int BACKLASH_NS = 20;
	localparam int BACKLASH_CYC = (BACKLASH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_W = 4;
	typedef enum logic [1:0] {
		PFD_IDLE = 2'b00,
		PFD_UP = 2'b01,
		PFD_DN = 2'b10,
		PFD_HOLD = 2'b11
	} pfd_state_t;
endpackage
